// ===== rtl/sbt_tap.sv
// Boundary-scan test access port of a burst memory: controller, instruction,
// bypass, identification and boundary registers, sampled on the system clock.
// Assumes the test clock is much slower than clock and pads pull TMS and TDI up.
`timescale 1ns/1ps
`default_nettype none
`include "sbt_consts.svh"

module sbt_tap
  import sbt_pkg::*;
#(
  parameter int               BSR_LEN  = `SBT_BSR_LEN,
  parameter int               OE_CELL  = `SBT_OE_CELL,
  parameter logic [31:0]      ID_VALUE = `SBT_ID_VALUE
) (
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic               testClock,
  input  wire logic               testModeSelect,
  input  wire logic               testDataIn,
  output logic                    testDataOut,
  output logic                    testDataOutEnable_n,
  input  wire logic [BSR_LEN-1:0] pinRing,
  output logic      [BSR_LEN-1:0] bsrDrive,
  output logic                    extestActive,
  output logic                    readBusHighZ
);

  logic [2:0]         linkSync;
  logic               tckPrev_q;
  logic               tckRise;
  logic               tckFall;
  logic               tmsS;
  logic               tdiS;
  logic [BSR_LEN-1:0] pinSync;
  sbt_state_type      state_q;
  sbt_state_type      state_d;
  sbt_instr_type      irShift_q;
  sbt_instr_type      instr_q;
  logic [31:0]        idShift_q;
  logic               bypass_q;
  logic               selBsr;
  logic               selId;
  logic               inShift;
  logic               bsrOut;
  logic               drOut;
  logic               tdo_q;
  logic               tdoEn_n_q;
  logic               extest_q;
  logic               highZ_q;

  // TMS and TDI reset to one, the level the pad pull-ups give an open pin.
  sbt_link_sync #(
    .WIDTH      (3),
    .RESET_BITS (3'h6)
  ) u_link_sync (
    .clock   (clock),
    .reset   (reset),
    .asyncIn ({testDataIn, testModeSelect, testClock}),
    .syncOut (linkSync)
  );

  // The pin ring is captured asynchronously to its own traffic, so a value in
  // transition may be caught either way; the memory itself is never touched.
  sbt_link_sync #(
    .WIDTH      (BSR_LEN),
    .RESET_BITS ('0)
  ) u_pin_sync (
    .clock   (clock),
    .reset   (reset),
    .asyncIn (pinRing),
    .syncOut (pinSync)
  );

  assign tmsS = linkSync[1];
  assign tdiS = linkSync[2];

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tckPrev_q <= 1'b0;
    end else begin
      tckPrev_q <= linkSync[0];
    end
  end

  // A test clock held low never produces a rise, so an unused port stays reset.
  assign tckRise = linkSync[0] & ~tckPrev_q;
  assign tckFall = ~linkSync[0] & tckPrev_q;

  // Controller transition graph; TMS high from any state reaches reset within five rises.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RESET:    state_d = tmsS ? ST_RESET    : ST_IDLE;
      ST_IDLE:     state_d = tmsS ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   state_d = tmsS ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   state_d = tmsS ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_d = tmsS ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_d = tmsS ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: state_d = tmsS ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_d = tmsS ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   state_d = tmsS ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   state_d = tmsS ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   state_d = tmsS ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_d = tmsS ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_d = tmsS ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: state_d = tmsS ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_d = tmsS ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   state_d = tmsS ? ST_SEL_DR   : ST_IDLE;
      default:     state_d = ST_RESET;
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= ST_RESET;
    end else if (tckRise) begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irShift_q <= `SBT_IR_CAPTURE;
      instr_q   <= `SBT_OP_IDCODE;
    end else if (tckRise) begin
      // The rise that enters reset restores the instruction, so a reset controller
      // never runs on with the old one for a whole test clock period.
      if (state_d == ST_RESET) begin
        instr_q <= `SBT_OP_IDCODE;
      end
      case (state_q)
        ST_CAP_IR:   irShift_q <= `SBT_IR_CAPTURE;
        ST_SHIFT_IR: irShift_q <= {tdiS, irShift_q[2:1]};
        ST_UPD_IR:   instr_q   <= irShift_q;
        default:     ;
      endcase
    end
  end

  // Reserved opcodes fall through to bypass, the shortest harmless path.
  assign selBsr = (instr_q == `SBT_OP_EXTEST) || (instr_q == `SBT_OP_SAMPLE)
               || (instr_q == `SBT_OP_SAMPLEZ);
  assign selId  = (instr_q == `SBT_OP_IDCODE);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      idShift_q <= '0;
      bypass_q  <= 1'b0;
    end else if (tckRise) begin
      if (state_q == ST_CAP_DR) begin
        if (selId) begin
          idShift_q <= ID_VALUE;
        end
        if (!selBsr && !selId) begin
          bypass_q <= 1'b0;
        end
      end else if (state_q == ST_SHIFT_DR) begin
        if (selId) begin
          idShift_q <= {tdiS, idShift_q[31:1]};
        end
        if (!selBsr && !selId) begin
          bypass_q <= tdiS;
        end
      end
    end
  end

  // One cell per bump, spare bumps included, sized by BSR_LEN.
  sbt_bsr #(
    .LEN     (BSR_LEN),
    .OE_CELL (OE_CELL)
  ) u_bsr (
    .clock     (clock),
    .reset     (reset),
    .capture   (tckRise && state_q == ST_CAP_DR && selBsr),
    .shift     (tckRise && state_q == ST_SHIFT_DR && selBsr),
    .update    (tckRise && state_q == ST_UPD_DR && selBsr),
    .presetOe  (tckRise && state_d == ST_RESET),
    .serialIn  (tdiS),
    .pinRing   (pinSync),
    .serialOut (bsrOut),
    .held_q    (bsrDrive)
  );

  assign inShift = (state_q == ST_SHIFT_DR) || (state_q == ST_SHIFT_IR);

  always_comb begin
    if (selBsr) begin
      drOut = bsrOut;
    end else if (selId) begin
      drOut = idShift_q[0];
    end else begin
      drOut = bypass_q;
    end
  end

  // TDO is retimed at the fall so the far end samples it stable at the next rise.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tdo_q     <= 1'b0;
      tdoEn_n_q <= 1'b1;
    end else if (tckFall) begin
      tdo_q     <= (state_q == ST_SHIFT_IR) ? irShift_q[0] : drOut;
      tdoEn_n_q <= ~inShift;
    end
  end

  assign testDataOut         = tdo_q;
  assign testDataOutEnable_n = tdoEn_n_q;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      extest_q <= 1'b0;
      highZ_q  <= 1'b0;
    end else begin
      extest_q <= (instr_q == `SBT_OP_EXTEST);
      highZ_q  <= (instr_q == `SBT_OP_SAMPLEZ)
               || ((instr_q == `SBT_OP_EXTEST) && !bsrDrive[OE_CELL]);
    end
  end

  assign extestActive = extest_q;
  assign readBusHighZ = highZ_q;

  // Checking logic.
  logic [2:0] tmsHighCount;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tmsHighCount <= 3'h0;
    end else if (tckRise) begin
      if (!tmsS) begin
        tmsHighCount <= 3'h0;
      end else if (tmsHighCount != `SBT_RESET_TMS_HIGH) begin
        tmsHighCount <= tmsHighCount + 3'h1;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  chk_five_high_reset: assert property (
    tmsHighCount == `SBT_RESET_TMS_HIGH |-> state_q == ST_RESET)
    else $error("Controller not in reset after five TMS-high rises");
  chk_tdo_fall_only: assert property (
    $changed(testDataOut) |-> $past(tckFall))
    else $error("TDO changed away from a test clock fall");
  chk_tdo_enable_shift: assert property (
    tckFall |=> testDataOutEnable_n == !$past(inShift))
    else $error("TDO enable does not follow shift state");
  chk_ir_capture_bits: assert property (
    tckRise && state_q == ST_CAP_IR |=> irShift_q[1:0] == 2'b01)
    else $error("Capture-IR did not load 01");
  chk_instr_update_only: assert property (
    $changed(instr_q) |-> $past(tckRise)
      && ($past(state_q) == ST_UPD_IR || $past(state_d) == ST_RESET))
    else $error("Instruction changed outside Update-IR or reset");
  chk_idcode_at_reset: assert property (
    tckRise && state_d == ST_RESET |=> instr_q == `SBT_OP_IDCODE)
    else $error("Reset state did not load identification instruction");
  chk_id_capture_value: assert property (
    tckRise && state_q == ST_CAP_DR && selId |=> idShift_q == ID_VALUE)
    else $error("Identification value not captured");
  chk_bypass_cleared: assert property (
    tckRise && state_q == ST_CAP_DR && !selBsr && !selId |=> bypass_q == 1'b0)
    else $error("Bypass register not cleared at capture");
  chk_samplez_highz: assert property (
    instr_q == `SBT_OP_SAMPLEZ |=> readBusHighZ)
    else $error("Sample-Z did not release the read bus");
  chk_state_on_rise: assert property (
    !tckRise |=> $stable(state_q))
    else $error("Controller moved without a test clock rise");

  cov_id_shift: cover property (state_q == ST_SHIFT_DR && selId);
  cov_ir_shift: cover property (state_q == ST_SHIFT_IR ##[1:100] state_q == ST_UPD_IR);
  cov_extest_load: cover property (tckRise && state_q == ST_UPD_IR
                                   && irShift_q == `SBT_OP_EXTEST);
  cov_tms_reset: cover property (state_q == ST_IDLE ##[1:1000] state_q == ST_RESET);

endmodule

`default_nettype wire

// ===== rtl/sbt_consts.svh
// Constants of the boundary-scan test port: opcodes, register sizes and cell positions.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SBT_CONSTS_SVH
`define SBT_CONSTS_SVH

`define SBT_IR_WIDTH       3
`define SBT_IR_CAPTURE     3'h1
`define SBT_OP_EXTEST      3'h0
`define SBT_OP_IDCODE      3'h1
`define SBT_OP_SAMPLEZ     3'h2
`define SBT_OP_SAMPLE      3'h4
`define SBT_OP_BYPASS      3'h7
`define SBT_ID_WIDTH       32
// Identification value is arbitrary and names no maker; bit 0 stays one.
`define SBT_ID_VALUE       32'h0a5c_3e01
`define SBT_BSR_LEN        109
`define SBT_OE_CELL        108
`define SBT_RESET_TMS_HIGH 3'h5

`endif

// ===== rtl/sbt_pkg.sv
// Types shared by the boundary-scan test port modules.
// Assumes the constants header sits beside it.
`include "sbt_consts.svh"

package sbt_pkg;

  typedef enum logic [3:0] {
    ST_EXIT2_DR = 4'h0,
    ST_EXIT1_DR = 4'h1,
    ST_SHIFT_DR = 4'h2,
    ST_PAUSE_DR = 4'h3,
    ST_SEL_IR   = 4'h4,
    ST_UPD_DR   = 4'h5,
    ST_CAP_DR   = 4'h6,
    ST_SEL_DR   = 4'h7,
    ST_EXIT2_IR = 4'h8,
    ST_EXIT1_IR = 4'h9,
    ST_SHIFT_IR = 4'ha,
    ST_PAUSE_IR = 4'hb,
    ST_IDLE     = 4'hc,
    ST_UPD_IR   = 4'hd,
    ST_CAP_IR   = 4'he,
    ST_RESET    = 4'hf
  } sbt_state_type;

  typedef logic [`SBT_IR_WIDTH-1:0] sbt_instr_type;

endpackage

// ===== rtl/sbt_link_sync.sv
// Two-stage synchroniser for levels arriving from outside the clock domain.
// Assumes each bit is an independent level; no bus coherency is offered.
`timescale 1ns/1ps
`default_nettype none

module sbt_link_sync #(
  parameter int                WIDTH      = 1,
  parameter logic [WIDTH-1:0]  RESET_BITS = '0
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stage1_q <= RESET_BITS;
      syncOut  <= RESET_BITS;
    end else begin
      stage1_q <= asyncIn;
      syncOut  <= stage1_q;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/sbt_bsr.sv
// Boundary scan register: one shift cell and one held cell per package bump.
// Assumes capture, shift and update are single-cycle strobes aligned to test clock rises.
`timescale 1ns/1ps
`default_nettype none
`include "sbt_consts.svh"

module sbt_bsr
  import sbt_pkg::*;
#(
  parameter int LEN     = `SBT_BSR_LEN,
  parameter int OE_CELL = `SBT_OE_CELL
) (
  input  wire logic           clock,
  input  wire logic           reset,
  input  wire logic           capture,
  input  wire logic           shift,
  input  wire logic           update,
  input  wire logic           presetOe,
  input  wire logic           serialIn,
  input  wire logic [LEN-1:0] pinRing,
  output logic                serialOut,
  output logic      [LEN-1:0] held_q
);

  logic [LEN-1:0] shift_q;

  assign serialOut = shift_q[0];

  genvar i;
  generate
    for (i = 0; i < LEN; i++) begin : g_cell
      logic nextBit;
      // Serial data enters at the top cell and leaves at cell zero.
      if (i == LEN - 1) begin : g_top
        assign nextBit = serialIn;
      end else begin : g_mid
        assign nextBit = shift_q[i+1];
      end

      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          shift_q[i] <= 1'b0;
        end else if (capture) begin
          shift_q[i] <= pinRing[i];
        end else if (shift) begin
          shift_q[i] <= nextBit;
        end
      end

      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          held_q[i] <= (i == OE_CELL);
        end else if (presetOe && (i == OE_CELL)) begin
          held_q[i] <= 1'b1;
        end else if (update) begin
          held_q[i] <= shift_q[i];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ===== bench/sbt_scan_master.sv
// Behavioural serial test controller that drives the test port of the memory.
// Assumes clock is the bench's system clock; the bench calls tick for each test clock period.
`timescale 1ns/1ps
`default_nettype none

module sbt_scan_master (
  input  wire logic clock,
  output logic      testClock,
  output logic      testModeSelect,
  output logic      testDataIn,
  input  wire logic testDataOut,
  input  wire logic testDataOutEnable_n
);
  // The test clock stands low between frames, so an idle port is never clocked.
  initial begin
    testClock = 1'b0;
    testModeSelect = 1'b1;
    testDataIn = 1'b1;
  end

  // One 320 ns period: TMS and TDI change only while the clock is low. TDO is taken late in the
  // high phase because the design shows each bit three to four clocks after the fall.
  task automatic tick(input logic tms, input logic tdi, output logic tdo, output logic en_n);
    testModeSelect <= tms;
    testDataIn <= tdi;
    repeat (4) @(posedge clock);
    testClock <= 1'b1;
    repeat (4) @(posedge clock);
    // An undriven TDO has no pull, so the model shows the inverse of the last value.
    tdo = testDataOutEnable_n ? ~testDataOut : testDataOut;
    en_n = testDataOutEnable_n;
    testClock <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== bench/sram_boundary_scan_tap_tb.sv
// Self-checking bench for the boundary-scan test port: opcode table, scan paths and resets.
// Assumes the design files and the scan master model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "sbt_consts.svh"

module sram_boundary_scan_tap_tb;
  localparam int N     = `SBT_BSR_LEN;
  localparam int LIMIT = 30000;

  logic         clock;
  logic         reset;
  logic         testClock;
  logic         testModeSelect;
  logic         testDataIn;
  logic         testDataOut;
  logic         testDataOutEnable_n;
  logic [N-1:0] pinRing;
  logic [N-1:0] bsrDrive;
  logic         extestActive;
  logic         readBusHighZ;
  int           errorCnt;
  int           nCompared;
  int           cycles = 0;

  sbt_tap dut_u (
    .clock               (clock),
    .reset               (reset),
    .testClock           (testClock),
    .testModeSelect      (testModeSelect),
    .testDataIn          (testDataIn),
    .testDataOut         (testDataOut),
    .testDataOutEnable_n (testDataOutEnable_n),
    .pinRing             (pinRing),
    .bsrDrive            (bsrDrive),
    .extestActive        (extestActive),
    .readBusHighZ        (readBusHighZ)
  );

  sbt_scan_master master_u (
    .clock               (clock),
    .testClock           (testClock),
    .testModeSelect      (testModeSelect),
    .testDataIn          (testDataIn),
    .testDataOut         (testDataOut),
    .testDataOutEnable_n (testDataOutEnable_n)
  );

  always #20 clock = ~clock;

  task automatic check(input string what, input logic [N-1:0] exp, input logic [N-1:0] got);
    nCompared++;
    if (got !== exp) begin
      errorCnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tk(input logic tms, input logic tdi);
    logic o;
    logic e;
    master_u.tick(tms, tdi, o, e);
  endtask

  // Full scan from Idle back to Idle; bit i of dout is the bit shown while bit i of din went in.
  task automatic scan(input logic isIr, input logic [N-1:0] din, input int n,
                      output logic [N-1:0] dout);
    logic o;
    logic e;
    logic held;
    dout = '0;
    held = extestActive;
    tk(1'b1, 1'b1);
    if (isIr) begin
      tk(1'b1, 1'b1);
    end
    tk(1'b0, 1'b1);
    tk(1'b0, 1'b1);
    for (int i = 0; i < n; i++) begin
      master_u.tick(i == n - 1, din[i], o, e);
      dout[i] = o;
      check("tdo enable in shift", 1'b0, e);
    end
    check("instruction before update", held, extestActive);
    tk(1'b1, 1'b1);
    tk(1'b0, 1'b1);
    repeat (6) @(posedge clock);
    check("tdo enable in idle", 1'b1, testDataOutEnable_n);
  endtask

  task automatic testPowerUp();
    logic [N-1:0] d;
    check("enable at power-up", 1'b1, testDataOutEnable_n);
    check("held cells at power-up", N'(1) << `SBT_OE_CELL, bsrDrive);
    check("extest at power-up", 1'b0, extestActive);
    check("read bus at power-up", 1'b0, readBusHighZ);
    tk(1'b0, 1'b1);
    scan(1'b0, '1, 32, d);
    check("id after power-up", `SBT_ID_VALUE, d[31:0]);
    $display("test power-up done");
  endtask

  task automatic testOpcodes();
    logic [N-1:0] d;
    logic [N-1:0] din;
    logic [N-1:0] e;
    logic [N-1:0] held;
    held = N'(1) << `SBT_OE_CELL;
    for (int op = 0; op < 8; op++) begin
      din = {1'b1, {9{12'h3a6}}} ^ N'(op);
      pinRing <= ~pinRing;
      scan(1'b1, N'(op), 3, d);
      check("captured instruction", 3'h1, d[2:0]);
      check("extest flag", op == 0, extestActive);
      check("read bus off", op == 2, readBusHighZ);
      scan(1'b0, din, N, d);
      case (op)
        0, 2, 4: begin
          e = pinRing;
          held = din;
        end
        1: e = N'({din, `SBT_ID_VALUE});
        default: e = N'({din, 1'b0});
      endcase
      check("data register path", e, d);
      check("held cells", held, bsrDrive);
    end
    $display("test opcodes done");
  endtask

  // Test reset is entered from the middle of a shift, which takes exactly five rises.
  task automatic testOutputOff();
    logic [N-1:0] d;
    logic [N-1:0] din;
    din = {1'b0, {9{12'hc95}}};
    scan(1'b1, N'(`SBT_OP_SAMPLE), 3, d);
    scan(1'b0, din, N, d);
    check("preloaded cells", din, bsrDrive);
    check("read bus under sample", 1'b0, readBusHighZ);
    scan(1'b1, N'(`SBT_OP_EXTEST), 3, d);
    check("read bus under extest", 1'b1, readBusHighZ);
    tk(1'b1, 1'b1);
    tk(1'b0, 1'b1);
    tk(1'b0, 1'b1);
    repeat (4) tk(1'b1, 1'b1);
    check("extest before fifth rise", 1'b1, extestActive);
    tk(1'b1, 1'b1);
    repeat (4) @(posedge clock);
    check("extest after test reset", 1'b0, extestActive);
    check("output cell preset", 1'b1, bsrDrive[`SBT_OE_CELL]);
    check("read bus after test reset", 1'b0, readBusHighZ);
    tk(1'b0, 1'b1);
    scan(1'b0, '0, 32, d);
    check("id after test reset", `SBT_ID_VALUE, d[31:0]);
    $display("test output off done");
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errorCnt++;
      conclude();
    end
  end

  initial begin
    clock = 1'b0;
    reset = 1'b1;
    pinRing = {1'b1, {9{12'h5c3}}};
    errorCnt = 0;
    nCompared = 0;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    repeat (4) @(posedge clock);
    testPowerUp();
    testOpcodes();
    testOutputOff();
    conclude();
  end
endmodule
`default_nettype wire
